// >>> hdl/add_and_pkg.sv
package add_and_pkg;

  // Datapath widths and carry positions.
  localparam int DATA_W     = 8;
  localparam int NIBBLE_W   = 4;
  localparam int SIGN_BIT   = 7;
  localparam int PC_W_DFLT  = 13;
  localparam int PC_STEP    = 1;

  // Register port map and reset values.
  localparam int                REG_ADDR_W = 2;
  localparam logic [1:0]        REG_ACC    = 2'h0;
  localparam logic [1:0]        REG_FLAGS  = 2'h1;
  localparam logic [1:0]        REG_RESULT = 2'h2;
  localparam logic [7:0]        ACC_RST    = 8'h00;
  localparam logic [7:0]        RD_IDLE    = 8'h00;

  // Operations carried out by this datapath slice.
  typedef enum logic [2:0] {
    SUM_LITERAL_INTO_ACC,
    RELATIVE_JUMP_BY_ACC,
    SUM_ACC_WITH_MEMORY,
    SUM_ACC_MEMORY_WITH_RIPPLE,
    MASK_ACC_WITH_LITERAL,
    MASK_ACC_WITH_MEMORY
  } op_t;

  // Status flags; bit 0 carry, bit 1 nibble carry, bit 2 zero.
  typedef struct packed {
    logic zero;
    logic nibbleRippleOutBit;
    logic carry;
  } flags_t;

  localparam int     FLAGS_W   = 3;
  localparam flags_t FLAGS_RST = 3'h0;

  // One decoded instruction.
  typedef struct packed {
    op_t        op;
    logic [7:0] operand;
    logic       toMemory;
  } instr_t;

  typedef enum logic {
    EXEC_IDLE,
    JUMP_WAIT
  } exec_state_t;

endpackage

// >>> hdl/flag_adder.sv
`timescale 1ns/10ps
`default_nettype none
module flag_adder
  import add_and_pkg::*;
#(
  parameter int W   = add_and_pkg::DATA_W,
  parameter int NIB = add_and_pkg::NIBBLE_W
) (
  // Operands.
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  // Sum and carries.
  output logic [W-1:0]      sum,
  output logic              carryOut,
  output logic              nibbleOut
);

  logic [W:0]   full;
  logic [NIB:0] low;

  // Full sum and the low nibble sum share the same carry in.
  always_comb begin
    full      = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    low       = {1'b0, a[NIB-1:0]} + {1'b0, b[NIB-1:0]} + {{NIB{1'b0}}, cin};
    sum       = full[W-1:0];
    carryOut  = full[W];
    nibbleOut = low[NIB];
  end

endmodule
`default_nettype wire

// >>> hdl/add_and_datapath.sv
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module add_and_datapath
  import add_and_pkg::*;
#(
  parameter int PC_W = add_and_pkg::PC_W_DFLT
) (
  // Clock, reset and clock enable.
  input  wire logic                              mclk,
  input  wire logic                              nrst,
  input  wire logic                              ce,
  // Instruction request from the decoder.
  input  wire logic                              instrValid,
  input  wire add_and_pkg::instr_t               instr,
  input  wire logic [PC_W-1:0]                   pcNow,
  input  wire logic [add_and_pkg::DATA_W-1:0]    memRdata,
  output logic                                   instrReady,
  // Write back to data memory.
  output logic                                   memWrite,
  output logic [add_and_pkg::DATA_W-1:0]         memAddr,
  output logic [add_and_pkg::DATA_W-1:0]         memWdata,
  // Jump target to the sequencer.
  output logic                                   jumpLoad,
  output logic [PC_W-1:0]                        jumpTarget,
  // Register port.
  input  wire logic [add_and_pkg::REG_ADDR_W-1:0] regAddr,
  input  wire logic [add_and_pkg::DATA_W-1:0]    regWdata,
  input  wire logic                              regWrite,
  input  wire logic                              regRead,
  output logic [add_and_pkg::DATA_W-1:0]         regRdata
);

  logic [1:0]        rstPipe;
  logic              rstN;
  exec_state_t       state;
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] lastResult;
  flags_t            flags;
  logic              issue;
  logic              isLiteral;
  logic              isMask;
  logic              isSum;
  logic [DATA_W-1:0] opB;
  logic              cin;
  logic [DATA_W-1:0] sum;
  logic              carryOut;
  logic              nibbleOut;
  logic [DATA_W-1:0] result;
  logic [PC_W-1:0]   offset;
  logic [PC_W-1:0]   next_target;
  flags_t            next_flags;

  // Reset is released through two flops so the datapath leaves reset cleanly.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'h1};
    end
  end
  assign rstN = rstPipe[1];

  // Operand selection; literal ops ignore the memory byte.
  always_comb begin
    isLiteral = (instr.op == SUM_LITERAL_INTO_ACC) ||
                (instr.op == MASK_ACC_WITH_LITERAL);
    isMask    = (instr.op == MASK_ACC_WITH_LITERAL) ||
                (instr.op == MASK_ACC_WITH_MEMORY);
    isSum     = !isMask && (instr.op != RELATIVE_JUMP_BY_ACC);
    opB       = isLiteral ? instr.operand : memRdata;
    cin       = (instr.op == SUM_ACC_MEMORY_WITH_RIPPLE) && flags.carry;
  end

  flag_adder #(
    .W   (DATA_W),
    .NIB (NIBBLE_W)
  ) adder (
    .a         (acc),
    .b         (opB),
    .cin       (cin),
    .sum       (sum),
    .carryOut  (carryOut),
    .nibbleOut (nibbleOut)
  );

  // Result and flag update; mask ops leave both carries alone.
  always_comb begin
    result     = isMask ? (acc & opB) : sum;
    next_flags = flags;
    if (isSum) begin
      next_flags.carry              = carryOut;
      next_flags.nibbleRippleOutBit = nibbleOut;
      next_flags.zero               = (result == ACC_RST);
    end else if (isMask) begin
      next_flags.zero = (result == ACC_RST);
    end
  end

  // Jump offset sign extends so bytes from 80h upward step backwards.
  always_comb begin
    offset      = {{(PC_W-DATA_W){acc[SIGN_BIT]}}, acc};
    next_target = pcNow + PC_W'(PC_STEP) + offset;
  end

  // A jump occupies a second cycle; the request port stalls meanwhile.
  assign instrReady = (state == EXEC_IDLE);
  assign issue      = instrValid && instrReady && ce;
  assign jumpLoad   = (state == JUMP_WAIT);

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state <= EXEC_IDLE;
    end else if (ce) begin
      unique case (state)
        EXEC_IDLE: begin
          if (issue && instr.op == RELATIVE_JUMP_BY_ACC) begin
            state <= JUMP_WAIT;
          end
        end
        JUMP_WAIT: begin
          state <= EXEC_IDLE;
        end
      endcase
    end
  end

  // Jump target is captured at issue and stands until the next jump.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      jumpTarget <= '0;
    end else if (issue && instr.op == RELATIVE_JUMP_BY_ACC) begin
      jumpTarget <= next_target;
    end
  end

  // Accumulator; an instruction that loads it beats a register write in the same cycle.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      acc <= ACC_RST;
    end else if (ce) begin
      if (issue && instr.op != RELATIVE_JUMP_BY_ACC &&
          (isLiteral || !instr.toMemory)) begin
        acc <= result;
      end else if (regWrite && regAddr == REG_ACC) begin
        acc <= regWdata;
      end
    end
  end

  // Flags; the jump never touches them.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      flags <= FLAGS_RST;
    end else if (ce) begin
      if (issue && instr.op != RELATIVE_JUMP_BY_ACC) begin
        flags <= next_flags;
      end else if (regWrite && regAddr == REG_FLAGS) begin
        flags <= regWdata[FLAGS_W-1:0];
      end
    end
  end

  // Memory write back is a one-cycle pulse after the instruction.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      memWrite   <= 1'h0;
      memAddr    <= ACC_RST;
      memWdata   <= ACC_RST;
      lastResult <= ACC_RST;
    end else if (ce) begin
      memWrite <= issue && !isLiteral && instr.toMemory &&
                  instr.op != RELATIVE_JUMP_BY_ACC;
      if (issue && instr.op != RELATIVE_JUMP_BY_ACC) begin
        memAddr    <= instr.operand;
        memWdata   <= result;
        lastResult <= result;
      end
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= RD_IDLE;
    end else if (ce) begin
      regRdata <= RD_IDLE;
      if (regRead) begin
        unique case (regAddr)
          REG_ACC:    regRdata <= acc;
          REG_FLAGS:  regRdata <= DATA_W'(flags);
          REG_RESULT: regRdata <= lastResult;
          default:    regRdata <= RD_IDLE;
        endcase
      end
    end
  end

  // Checks.
  sequence seqJumpIssue;
    issue && instr.op == RELATIVE_JUMP_BY_ACC;
  endsequence

  sequence seqJumpWait;
    !instrReady && jumpLoad;
  endsequence

  chk_addlit_sum: assert property (@(posedge mclk) disable iff (!rstN)
    issue && instr.op == SUM_LITERAL_INTO_ACC |=>
      acc == DATA_W'($past(acc) + $past(instr.operand)))
    else $error("literal add result wrong");

  chk_jump_two: assert property (@(posedge mclk) disable iff (!rstN)
    seqJumpIssue |=> seqJumpWait ##1 (instrReady || !$past(ce)))
    else $error("jump did not take two cycles");

  chk_jump_target: assert property (@(posedge mclk) disable iff (!rstN)
    seqJumpIssue |=> jumpTarget == PC_W'($past(pcNow) + PC_W'(PC_STEP) +
      {{(PC_W-DATA_W){$past(acc[SIGN_BIT])}}, $past(acc)}))
    else $error("jump target wrong");

  chk_jump_flags: assert property (@(posedge mclk) disable iff (!rstN)
    (seqJumpIssue and !(regWrite && regAddr == REG_FLAGS)) |=>
      $stable(flags))
    else $error("jump changed flags");

  chk_mem_sum: assert property (@(posedge mclk) disable iff (!rstN)
    issue && instr.op == SUM_ACC_WITH_MEMORY && instr.toMemory |=>
      memWrite && memWdata == DATA_W'($past(acc) + $past(memRdata)) &&
      flags.carry == (({1'b0, $past(acc)} + {1'b0, $past(memRdata)}) >> DATA_W))
    else $error("memory add wrong");

  chk_dest_mem: assert property (@(posedge mclk) disable iff (!rstN)
    issue && !isLiteral && instr.toMemory &&
      instr.op != RELATIVE_JUMP_BY_ACC && !regWrite |=>
      memWrite && acc == $past(acc))
    else $error("memory destination touched accumulator");

  chk_dest_acc: assert property (@(posedge mclk) disable iff (!rstN)
    issue && !instr.toMemory |=> !memWrite)
    else $error("accumulator destination wrote memory");

  chk_ripple_sum: assert property (@(posedge mclk) disable iff (!rstN)
    issue && instr.op == SUM_ACC_MEMORY_WITH_RIPPLE && !instr.toMemory |=>
      {flags.carry, acc} == ({1'b0, $past(acc)} + {1'b0, $past(memRdata)} +
        {{DATA_W{1'b0}}, $past(flags.carry)}))
    else $error("ripple add wrong");

  chk_mask_flags: assert property (@(posedge mclk) disable iff (!rstN)
    issue && isMask |=> flags.carry == $past(flags.carry) &&
      flags.nibbleRippleOutBit == $past(flags.nibbleRippleOutBit) &&
      flags.zero == (memWdata == ACC_RST))
    else $error("mask flags wrong");

  chk_mask_single: assert property (@(posedge mclk) disable iff (!rstN)
    issue && instr.op == MASK_ACC_WITH_MEMORY |=> instrReady &&
      memWdata == ($past(acc) & $past(memRdata)))
    else $error("memory mask not one cycle");

  chk_nibble_carry: assert property (@(posedge mclk) disable iff (!rstN)
    issue && instr.op == SUM_LITERAL_INTO_ACC |=>
      flags.nibbleRippleOutBit == ((({1'b0, $past(acc[NIBBLE_W-1:0])} +
        {1'b0, $past(instr.operand[NIBBLE_W-1:0])}) >> NIBBLE_W) != 0))
    else $error("nibble carry wrong");

  chk_masklit_val: assert property (@(posedge mclk) disable iff (!rstN)
    issue && instr.op == MASK_ACC_WITH_LITERAL |=>
      acc == ($past(acc) & $past(instr.operand)) && !memWrite)
    else $error("literal mask wrong");

endmodule
`default_nettype wire

// >>> bench/dmem_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmem_model (
  // Clock.
  input  wire logic       mclk,
  // Read side, answered in the same cycle.
  input  wire logic [7:0] rdAddr,
  output logic [7:0]      rdData,
  // Write side, taken on a rising edge.
  input  wire logic       wrEn,
  input  wire logic [7:0] wrAddr,
  input  wire logic [7:0] wrData
);
  logic [7:0] mem [256];

  // Fixed pattern at start so the bench can mirror every byte.
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  // The byte must be there in the issue cycle, so the read has no delay.
  assign rdData = mem[rdAddr];

  // Write back from the datapath.
  always @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end
endmodule
`default_nettype wire

// >>> bench/add_and_datapath_test.sv
`timescale 1ns/10ps
`default_nettype none
module add_and_datapath_test;
  import add_and_pkg::*;
  logic mclk, nrst, ce, instrValid, instrReady, memWrite, jumpLoad;
  logic regWrite, regRead;
  instr_t instr;
  logic [12:0] pcNow, jumpTarget;
  logic [7:0] memRdata, memAddr, memWdata, regWdata, regRdata, acc;
  logic [7:0] mirror [256];
  logic [1:0] regAddr;
  logic [2:0] flg;
  int numErrors, totalChecks;
  op_t op;

  add_and_datapath i_dut (.mclk(mclk), .nrst(nrst), .ce(ce),
    .instrValid(instrValid), .instr(instr), .pcNow(pcNow),
    .memRdata(memRdata), .instrReady(instrReady), .memWrite(memWrite),
    .memAddr(memAddr), .memWdata(memWdata), .jumpLoad(jumpLoad),
    .jumpTarget(jumpTarget), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));

  dmem_model i_mem (.mclk(mclk), .rdAddr(instr.operand), .rdData(memRdata),
    .wrEn(memWrite), .wrAddr(memAddr), .wrData(memWdata));

  // Free-running clock at 200 MHz.
  always #2.5 mclk = ~mclk;

  task automatic stopTest;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Expected result and flags {zero, nibble, carry} of one operation.
  function automatic logic [10:0] calc(op_t o, logic [7:0] a, logic [7:0] b,
                                       logic [2:0] f);
    logic [8:0] s;
    logic [4:0] n;
    logic       ci;
    ci = (o == SUM_ACC_MEMORY_WITH_RIPPLE) ? f[0] : 1'b0;
    s = {1'b0, a} + {1'b0, b} + 9'(ci);
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
    if (o == MASK_ACC_WITH_LITERAL || o == MASK_ACC_WITH_MEMORY) begin
      return {(a & b) == 8'h00, f[1:0], a & b};
    end
    return {s[7:0] == 8'h00, n[4], s[8], s[7:0]};
  endfunction

  // Register access; every task starts and ends just after an edge.
  task automatic rd(logic [1:0] a, logic [7:0] e);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    #1 regRead <= 1'b0;
    check(regRdata, e);
    @(posedge mclk);
    #1;
  endtask

  task automatic wr(logic [1:0] a, logic [7:0] d);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge mclk);
    #1 regWrite <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic runOp(op_t o, logic [7:0] k, logic d);
    logic [10:0] e;
    logic        lit;
    lit = (o == SUM_LITERAL_INTO_ACC || o == MASK_ACC_WITH_LITERAL);
    e = calc(o, acc, lit ? k : mirror[k], flg);
    instrValid <= 1'b1;
    instr <= '{o, k, d};
    @(posedge mclk);
    #1 instrValid <= 1'b0;
    check(memWrite, !lit && d);
    if (!lit && d) begin
      check(memWdata, e[7:0]);
      mirror[k] = e[7:0];
    end else begin
      acc = e[7:0];
    end
    flg = e[10:8];
    @(posedge mclk);
    #1;
    rd(REG_ACC, acc);
    rd(REG_FLAGS, {5'h0, flg});
    check(i_mem.mem[k], mirror[k]);
  endtask

  task automatic jump(logic [7:0] w, logic [12:0] pc);
    wr(REG_ACC, w);
    acc = w;
    instrValid <= 1'b1;
    instr <= '{RELATIVE_JUMP_BY_ACC, 8'h00, 1'b0};
    pcNow <= pc;
    @(posedge mclk);
    #1 instrValid <= 1'b0;
    check({jumpLoad, instrReady}, 2'b10);
    check(jumpTarget, 13'(pc + 13'd1 + {{5{w[7]}}, w}));
    @(posedge mclk);
    #1 check({jumpLoad, instrReady}, 2'b01);
    rd(REG_FLAGS, {5'h0, flg});
    rd(REG_ACC, w);
  endtask

  // A hang ends the run as a failure.
  initial begin
    repeat (100000) @(posedge mclk);
    numErrors++;
    stopTest();
  end

  // Main sequence: examples, boundaries, then random traffic.
  initial begin
    mclk = 1'b0; nrst = 1'b0; ce = 1'b1; instrValid = 1'b0; instr = '0;
    pcNow = '0; regAddr = '0; regWdata = '0; regWrite = 1'b0;
    regRead = 1'b0; acc = 8'h00; flg = 3'h0;
    for (int i = 0; i < 256; i++) begin
      mirror[i] = 8'(i) ^ 8'h5a;
    end
    void'($urandom(73968));
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 rd(REG_ACC, 8'h00);
    rd(REG_FLAGS, 8'h00);
    jump(8'h7f, 13'h0212);
    jump(8'h80, 13'h0212);
    jump(8'hfe, 13'h0212);
    wr(REG_ACC, 8'hff);
    acc = 8'hff;
    runOp(SUM_LITERAL_INTO_ACC, 8'h01, 1'b0);
    rd(2'h2, 8'h00);
    wr(2'h3, 8'ha5);
    rd(2'h3, 8'h00);
    // With the clock enable low an offered instruction must not be taken.
    ce <= 1'b0;
    instrValid <= 1'b1;
    instr <= '{SUM_LITERAL_INTO_ACC, 8'h11, 1'b0};
    @(posedge mclk);
    #1 instrValid <= 1'b0;
    ce <= 1'b1;
    rd(REG_ACC, acc);
    repeat (300) begin
      op = op_t'($urandom_range(5, 0));
      if (op == RELATIVE_JUMP_BY_ACC) begin
        jump(8'($urandom), 13'($urandom));
      end else begin
        if ($urandom_range(3, 0) == 0) begin
          acc = 8'($urandom);
          flg = 3'($urandom);
          wr(REG_ACC, acc);
          wr(REG_FLAGS, {5'h0, flg});
        end
        runOp(op, 8'($urandom), 1'($urandom));
      end
    end
    stopTest();
  end
endmodule
`default_nettype wire
